// ===== src/shdm_params.svh
// Register offsets, field positions, reset values and limits of the monitor
`ifndef SHDM_PARAMS_SVH
`define SHDM_PARAMS_SVH
`define SHDM_OFS_CTRL 12'h000
`define SHDM_OFS_NUM 12'h004
`define SHDM_OFS_DEN 12'h008
`define SHDM_OFS_LIMIT 12'h00c
`define SHDM_OFS_TURNS 12'h010
`define SHDM_OFS_STATUS 12'h014
`define SHDM_OFS_SCALE 12'h018
`define SHDM_OFS_ENC 12'h01c
`define SHDM_OFS_DEV 12'h020
`define SHDM_OFS_INT 12'h024
`define SHDM_OFS_MASK 12'h028
`define SHDM_CTRL_ACLR_BIT 4
`define SHDM_INT_EXCESS 0
`define SHDM_INT_PERIODIC 1
`define SHDM_INT_EVENT 2
`define SHDM_RST_NUM 24'h000000
`define SHDM_RST_DEN 24'h000001
`define SHDM_RST_LIMIT 28'h0003e80
`define SHDM_RST_TURNS 7'h00
`define SHDM_NUM_MAX 24'h800000
`define SHDM_LIMIT_MAX 28'h8000000
`define SHDM_TURNS_MAX 7'h64
`endif

// ===== src/shdm_pkg.sv
// Types and phase decoding shared by the monitor modules
package shdm_pkg;
  typedef logic signed [63:0] shdm_dev_t;
  typedef enum logic [1:0] {
    SHDM_APB_IDLE = 2'b01,
    SHDM_APB_RESP = 2'b10
  } shdm_apb_e;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
    logic [2:0] arm;
    logic up;
    logic dn;
  } shdm_qd_s;
  typedef struct packed {
    logic signed [24:0] pos;
    logic [6:0] done;
    logic clr;
  } shdm_rev_s;
  typedef struct packed {
    shdm_apb_e apb_st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] dir_inv;
    logic [23:0] num;
    logic [23:0] den;
    logic [27:0] limit;
    logic [6:0] turns;
    logic [2:0] int_sts;
    logic [2:0] int_mask;
    logic irq;
    logic [31:0] scale_pos;
    logic [31:0] enc_pos;
    shdm_dev_t dev;
    logic [51:0] thresh;
    logic err;
  } shdm_top_s;

  // Phase pair change {a,b} old to new; returns {up,dn}
  function automatic logic [1:0] shdm_quad_step(input logic [1:0] p, input logic [1:0] c);
    case ({p, c})
      4'h2, 4'hb, 4'hd, 4'h4: shdm_quad_step = 2'b01;
      4'h1, 4'h7, 4'he, 4'h8: shdm_quad_step = 2'b10;
      default: shdm_quad_step = 2'b00;
    endcase
  endfunction
endpackage

// ===== src/shdm_step_if.sv
// Count step pulses from a quadrature decoder
`timescale 1ns/100ps
interface shdm_step_if;
  logic up;
  logic dn;
  modport src (output up, output dn);
  modport snk (input up, input dn);
endinterface

// ===== src/shdm_quad_dec.sv
// Quadrature decoder with pin synchroniser and count sense swap
`timescale 1ns/100ps
module shdm_quad_dec
  import shdm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Phase pins and sense
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic invert_i,
  // Count steps
  shdm_step_if.src step
);
  shdm_qd_s st;
  shdm_qd_s next_st;
  logic [1:0] dir;

  // Synchronise pins, decode legal changes, swap sense on request
  always_comb
  begin
    next_st = st;
    next_st.s1 = {phase_a_i, phase_b_i};
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    next_st.arm = {st.arm[1:0], 1'b1};
    dir = st.arm[2] ? shdm_quad_step(st.prev, st.s2) : 2'b00;
    next_st.up = invert_i ? dir[0] : dir[1];
    next_st.dn = invert_i ? dir[1] : dir[0];
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign step.up = st.up;
  assign step.dn = st.dn;

  // Sense checks
  chk_lag_down: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.arm[2] && !invert_i && st.prev == 2'b00 && st.s2 == 2'b10 |=> st.dn && !st.up)
    else $error("lagging phase b did not count down");
  chk_lag_up_inv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.arm[2] && invert_i && st.prev == 2'b10 && st.s2 == 2'b11 |=> st.up && !st.dn)
    else $error("inverted lagging phase b did not count up");
endmodule

// ===== src/shdm_rev_cnt.sv
// Motor turn counter that requests the periodic deviation clear
`timescale 1ns/100ps
module shdm_rev_cnt
  import shdm_pkg::*;
#(
  parameter int unsigned ENC_RES = 8388608
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Encoder steps and setting
  shdm_step_if.snk enc,
  input wire logic [6:0] turns_i,
  input wire logic restart_i,
  // Periodic clear pulse
  output logic clr_o
);
  localparam logic signed [24:0] RES = 25'(ENC_RES);
  shdm_rev_s st;
  shdm_rev_s next_st;

  // Resolution must fit the signed turn position
  if (ENC_RES < 2 || ENC_RES > 8388608)
  begin : g_bad_res
    $error("ENC_RES out of range");
  end

  // Count encoder steps into whole turns in either direction
  always_comb
  begin
    next_st = st;
    next_st.clr = 1'b0;
    if (enc.up)
      next_st.pos = st.pos + 25'sh0000001;
    if (enc.dn)
      next_st.pos = st.pos - 25'sh0000001;
    if (next_st.pos == RES || next_st.pos == -RES)
    begin
      next_st.pos = '0;
      next_st.done = st.done + 7'h01;
    end
    if (turns_i != 7'h00 && next_st.done >= turns_i)
    begin
      next_st.clr = 1'b1;
      next_st.done = '0;
    end
    if (restart_i)
    begin
      next_st.pos = '0;
      next_st.done = '0;
      next_st.clr = 1'b0;
    end
    else if (turns_i == 7'h00)
      next_st.done = '0;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign clr_o = st.clr;

  // Turn clear checks
  chk_zero_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    turns_i == 7'h00 |=> !clr_o)
    else $error("periodic clear with zero turn setting");
  chk_turn_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.pos == RES - 25'sh0000001 && enc.up && !restart_i && turns_i != 7'h00
    && st.done == turns_i - 7'h01 |=> clr_o)
    else $error("no clear after the programmed turns");
endmodule

// ===== src/shdm_top.sv
// Top of the full-closed hybrid deviation monitor with APB registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "shdm_params.svh"
// Overview of operation
// - Non-inverted scale counts down when B lags A, up when B leads
// - Inverted scale swaps the counting sense of the scale counter
// - Ratio numerator is accepted from zero to two to the 23rd
// - A zero numerator is replaced by the encoder resolution
// - Ratio denominator runs one to two to the 23rd; zero is refused
// - Deviation beyond the limit raises the excess error
// - Limit is counted in command units, here encoder counts
// - Deviation cleared every programmed number of turns, zero to 100
// - A turn setting of zero disables periodic clearing
// - Turns are counted from encoder pulses, never scale pulses
// - Absolute system power-up initialisation clears the deviation
// - Fieldbus change from init to pre-operational clears the deviation
// - Completed homing clears the deviation
// - Completed setup-tool functions clear the deviation
// - A raised command fault clears the deviation
// - Direction setting: 0 normal, 1 inverted, others reserved
module shdm_top
  import shdm_pkg::*;
#(
  parameter int unsigned ENC_RES = 8388608
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Scale and encoder pins
  input wire logic scale_phase_a_i,
  input wire logic scale_phase_b_i,
  input wire logic enc_phase_a_i,
  input wire logic enc_phase_b_i,
  // Position initialisation events
  input wire logic abs_init_i,
  input wire logic esm_preop_i,
  input wire logic homing_done_i,
  input wire logic setup_done_i,
  input wire logic command_fault_i,
  // Protection and interrupt
  output logic hybrid_err_o,
  output logic irq_o
);
  localparam shdm_top_s TOP_RST = '{
    apb_st: SHDM_APB_IDLE,
    num: `SHDM_RST_NUM,
    den: `SHDM_RST_DEN,
    limit: `SHDM_RST_LIMIT,
    turns: `SHDM_RST_TURNS,
    default: '0
  };

  shdm_top_s st;
  shdm_top_s next_st;
  logic [1:0] rst_q;
  logic rst_n;
  logic scale_inv;
  logic clr_evt;
  logic turn_clr;
  logic excess;
  logic aclr;
  logic [2:0] rd_clr;
  logic [2:0] set_v;
  logic [23:0] num_eff;
  logic [31:0] rd_data;
  shdm_dev_t num_w;
  shdm_dev_t den_w;
  shdm_dev_t step;
  shdm_dev_t mag;

  shdm_step_if sc_s();
  shdm_step_if enc_s();

  // Resolution must fit the numerator field
  if (ENC_RES < 2 || ENC_RES > 8388608)
  begin : g_bad_res
    $error("ENC_RES out of range");
  end

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  assign rst_n = rst_q[1];

  // Reserved direction codes count as non-inverted
  assign scale_inv = (st.dir_inv == 2'b01);

  // Position initialisation events
  assign clr_evt = abs_init_i
    | esm_preop_i
    | homing_done_i
    | setup_done_i
    | command_fault_i;

  // Load-side scale decoder
  shdm_quad_dec u_scale (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .phase_a_i(scale_phase_a_i),
    .phase_b_i(scale_phase_b_i),
    .invert_i(scale_inv),
    .step(sc_s)
  );

  // Motor encoder decoder
  shdm_quad_dec u_enc (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .phase_a_i(enc_phase_a_i),
    .phase_b_i(enc_phase_b_i),
    .invert_i(1'b0),
    .step(enc_s)
  );

  // Turn counter driven by the encoder only
  shdm_rev_cnt #(
    .ENC_RES(ENC_RES)
  ) u_rev (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .enc(enc_s),
    .turns_i(st.turns),
    .restart_i(clr_evt),
    .clr_o(turn_clr)
  );

  // Offsets that answer on the bus
  function automatic logic shdm_hit(input logic [11:0] a);
    case (a)
      `SHDM_OFS_CTRL, `SHDM_OFS_NUM, `SHDM_OFS_DEN, `SHDM_OFS_LIMIT,
      `SHDM_OFS_TURNS, `SHDM_OFS_STATUS, `SHDM_OFS_SCALE, `SHDM_OFS_ENC,
      `SHDM_OFS_DEV, `SHDM_OFS_INT, `SHDM_OFS_MASK: shdm_hit = 1'b1;
      default: shdm_hit = 1'b0;
    endcase
  endfunction

  // Writes whose value lies in the setting's range
  function automatic logic shdm_wr_ok(input logic [11:0] a, input logic [31:0] d);
    case (a)
      `SHDM_OFS_CTRL: shdm_wr_ok = (d[1:0] <= 2'b01);
      `SHDM_OFS_NUM: shdm_wr_ok = (d <= {8'h00, `SHDM_NUM_MAX});
      `SHDM_OFS_DEN: shdm_wr_ok = (d != 32'h0) && (d <= {8'h00, `SHDM_NUM_MAX});
      `SHDM_OFS_LIMIT: shdm_wr_ok = (d != 32'h0) && (d <= {4'h0, `SHDM_LIMIT_MAX});
      `SHDM_OFS_TURNS: shdm_wr_ok = (d <= {25'h0, `SHDM_TURNS_MAX});
      default: shdm_wr_ok = shdm_hit(a);
    endcase
  endfunction

  // Read data for the addressed register
  always_comb
  begin
    case (paddr_i)
      `SHDM_OFS_CTRL: rd_data = {30'h0, st.dir_inv};
      `SHDM_OFS_NUM: rd_data = {8'h00, st.num};
      `SHDM_OFS_DEN: rd_data = {8'h00, st.den};
      `SHDM_OFS_LIMIT: rd_data = {4'h0, st.limit};
      `SHDM_OFS_TURNS: rd_data = {25'h0, st.turns};
      `SHDM_OFS_STATUS: rd_data = {31'h0, st.err};
      `SHDM_OFS_SCALE: rd_data = st.scale_pos;
      `SHDM_OFS_ENC: rd_data = st.enc_pos;
      `SHDM_OFS_DEV: rd_data = st.dev[31:0];
      `SHDM_OFS_INT: rd_data = {29'h0, st.int_sts};
      `SHDM_OFS_MASK: rd_data = {29'h0, st.int_mask};
      default: rd_data = 32'h0;
    endcase
  end

  // Deviation magnitude against the limit in encoder counts
  assign mag = st.dev[63] ? -st.dev : st.dev;
  assign excess = (mag > {12'h000, st.thresh});

  // Next state of the monitor
  always_comb
  begin
    next_st = st;
    aclr = 1'b0;
    rd_clr = 3'b000;
    num_eff = (st.num == 24'h000000) ? 24'(ENC_RES) : st.num;
    num_w = {40'h0, num_eff};
    den_w = {40'h0, st.den};
    step = '0;
    next_st.pready = 1'b0;
    // Bus slave with one wait cycle
    case (st.apb_st)
      SHDM_APB_IDLE:
      begin
        if (psel_i && penable_i)
        begin
          next_st.apb_st = SHDM_APB_RESP;
          next_st.pready = 1'b1;
          next_st.prdata = pwrite_i ? 32'h0 : rd_data;
          next_st.pslverr = pwrite_i ? !shdm_wr_ok(paddr_i, pwdata_i) : !shdm_hit(paddr_i);
        end
      end
      SHDM_APB_RESP:
      begin
        next_st.apb_st = SHDM_APB_IDLE;
        next_st.pslverr = 1'b0;
        if (psel_i && penable_i && !st.pslverr)
        begin
          if (pwrite_i)
          begin
            case (paddr_i)
              `SHDM_OFS_CTRL:
              begin
                next_st.dir_inv = pwdata_i[1:0];
                aclr = pwdata_i[`SHDM_CTRL_ACLR_BIT];
              end
              `SHDM_OFS_NUM: next_st.num = pwdata_i[23:0];
              `SHDM_OFS_DEN: next_st.den = pwdata_i[23:0];
              `SHDM_OFS_LIMIT: next_st.limit = pwdata_i[27:0];
              `SHDM_OFS_TURNS: next_st.turns = pwdata_i[6:0];
              `SHDM_OFS_MASK: next_st.int_mask = pwdata_i[2:0];
              default: next_st.int_mask = st.int_mask;
            endcase
          end
          else if (paddr_i == `SHDM_OFS_INT)
            rd_clr = st.prdata[2:0];
        end
      end
      default: next_st.apb_st = SHDM_APB_IDLE;
    endcase
    // Raw position counters, never cleared
    if (sc_s.up)
      next_st.scale_pos = st.scale_pos + 32'h00000001;
    if (sc_s.dn)
      next_st.scale_pos = st.scale_pos - 32'h00000001;
    if (enc_s.up)
      next_st.enc_pos = st.enc_pos + 32'h00000001;
    if (enc_s.dn)
      next_st.enc_pos = st.enc_pos - 32'h00000001;
    // Encoder times num less scale times den
    if (enc_s.up)
      step = step + num_w;
    if (enc_s.dn)
      step = step - num_w;
    if (sc_s.up)
      step = step - den_w;
    if (sc_s.dn)
      step = step + den_w;
    if (clr_evt || turn_clr)
      next_st.dev = '0;
    else
      next_st.dev = st.dev + step;
    next_st.thresh = st.limit * num_eff;
    // Error latch, a new excess beats the alarm clear
    next_st.err = excess | (st.err & ~aclr);
    // Sticky events, set beats the read clear
    set_v = 3'b000;
    set_v[`SHDM_INT_EXCESS] = excess & ~st.err;
    set_v[`SHDM_INT_PERIODIC] = turn_clr;
    set_v[`SHDM_INT_EVENT] = clr_evt;
    next_st.int_sts = (st.int_sts & ~rd_clr) | set_v;
    next_st.irq = |(next_st.int_sts & next_st.int_mask);
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      st <= TOP_RST;
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign hybrid_err_o = st.err;
  assign irq_o = st.irq;

  // Checks on the monitor
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_apb_access;
    psel_i && penable_i && st.apb_st == SHDM_APB_IDLE;
  endsequence

  sequence s_apb_answer;
    pready_o ##1 !pready_o;
  endsequence

  sequence s_den_zero;
    s_apb_access and (pwrite_i && paddr_i == `SHDM_OFS_DEN && pwdata_i == 32'h0);
  endsequence

  chk_apb_answer: assert property (s_apb_access |=> s_apb_answer)
    else $error("bus access not answered after one wait cycle");
  chk_den_refused: assert property (s_den_zero |=> pslverr_o ##1 st.den != 24'h000000)
    else $error("zero denominator was accepted");
  chk_num_zero: assert property (
    st.num == 24'h000000 && enc_s.up && !sc_s.up && !sc_s.dn && !clr_evt && !turn_clr
    |=> st.dev == $past(st.dev) + shdm_dev_t'(ENC_RES))
    else $error("zero numerator did not use the encoder resolution");
  chk_scale_step: assert property (
    sc_s.dn && !enc_s.up && !enc_s.dn && !clr_evt && !turn_clr
    |=> st.dev == $past(st.dev) + $past(den_w))
    else $error("scale step did not move the deviation by the denominator");
  chk_excess_raise: assert property (excess |=> hybrid_err_o)
    else $error("excess deviation did not raise the error");
  chk_err_latched: assert property (hybrid_err_o && !aclr |=> hybrid_err_o)
    else $error("excess error dropped without an alarm clear");
  chk_event_clear: assert property (clr_evt |=> st.dev == '0)
    else $error("initialisation event did not clear the deviation");
  chk_turn_zero: assert property (turn_clr |=> st.dev == '0)
    else $error("periodic clear did not zero the deviation");
  chk_irq_raise: assert property ($rose(st.int_sts[`SHDM_INT_EXCESS])
    && st.int_mask[`SHDM_INT_EXCESS] |-> irq_o)
    else $error("unmasked event did not raise the interrupt");
endmodule

// ===== sim/shdm_quad_model.sv
// Behavioural quadrature source standing in for the scale or the encoder
`timescale 1ns/100ps
module shdm_quad_model
(
  // Clock
  input wire logic clk_i,
  // Phase pins
  output logic phase_a_o,
  output logic phase_b_o
);
  logic [1:0] pos = 2'h0;
  // Gray sequence, rising index makes B lag A
  always_comb
  begin
    case (pos)
      2'h0: {phase_a_o, phase_b_o} = 2'b00;
      2'h1: {phase_a_o, phase_b_o} = 2'b10;
      2'h2: {phase_a_o, phase_b_o} = 2'b11;
      default: {phase_a_o, phase_b_o} = 2'b01;
    endcase
  end
  // Positive n lags, negative leads; each level held 7 cycles, past the sync
  task automatic move(input int n);
    int i;
    for (i = 0; i < (n < 0 ? -n : n); i++)
    begin
      @(posedge clk_i);
      pos <= (n > 0) ? pos + 2'h1 : pos - 2'h1;
      repeat (6) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ===== sim/test_scale_hybrid_deviation_monitor.sv
// Self-checking bench of the hybrid deviation monitor
`timescale 1ns/100ps
`include "shdm_params.svh"
module test_scale_hybrid_deviation_monitor;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic s_a;
  logic s_b;
  logic e_a;
  logic e_b;
  logic [4:0] ev = 5'h00;
  logic herr;
  logic irq;
  int n_mismatch = 0;
  int check_count = 0;
  // Far side pin sources
  shdm_quad_model sc (.clk_i(clk), .phase_a_o(s_a), .phase_b_o(s_b));
  shdm_quad_model en (.clk_i(clk), .phase_a_o(e_a), .phase_b_o(e_b));
  // Block under test with a short turn
  shdm_top #(.ENC_RES(16)) uut (
    .ref_clk_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .scale_phase_a_i(s_a), .scale_phase_b_i(s_b), .enc_phase_a_i(e_a), .enc_phase_b_i(e_b),
    .abs_init_i(ev[0]), .esm_preop_i(ev[1]), .homing_done_i(ev[2]), .setup_done_i(ev[3]),
    .command_fault_i(ev[4]), .hybrid_err_o(herr), .irq_o(irq));
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      n_mismatch++;
      $display("[FAIL] apb answer expected 1 seen 0");
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(what, {31'h0, x}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, x, q);
    chk(what, 32'h0, {31'h0, e});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 5'h01 << i;
    @(posedge clk);
    ev <= 5'h00;
    repeat (2) @(posedge clk);
  endtask
  // Reset values and an unmapped place
  task automatic t_reset();
    rd(`SHDM_OFS_NUM, 32'h0, "num");
    rd(`SHDM_OFS_DEN, 32'h1, "den");
    rd(`SHDM_OFS_LIMIT, 32'h3e80, "limit");
    rd(`SHDM_OFS_TURNS, 32'h0, "turns");
    rd(`SHDM_OFS_MASK, 32'h0, "mask");
    rd(`SHDM_OFS_STATUS, 32'h0, "status");
    wr(12'h02c, 32'h1, 1'b1, "unmapped");
  endtask
  // Out-of-range settings refused, boundaries taken
  task automatic t_refuse();
    wr(`SHDM_OFS_DEN, 32'h0, 1'b1, "den0");
    wr(`SHDM_OFS_DEN, 32'h800001, 1'b1, "denbig");
    rd(`SHDM_OFS_DEN, 32'h1, "den");
    wr(`SHDM_OFS_NUM, 32'h800001, 1'b1, "numbig");
    wr(`SHDM_OFS_NUM, 32'h800000, 1'b0, "nummax");
    rd(`SHDM_OFS_NUM, 32'h800000, "num");
    wr(`SHDM_OFS_LIMIT, 32'h0, 1'b1, "limit0");
    wr(`SHDM_OFS_TURNS, 32'd101, 1'b1, "turns101");
    wr(`SHDM_OFS_TURNS, 32'd100, 1'b0, "turns100");
    rd(`SHDM_OFS_TURNS, 32'd100, "turns");
    wr(`SHDM_OFS_CTRL, 32'h2, 1'b1, "dir2");
    wr(`SHDM_OFS_CTRL, 32'h3, 1'b1, "dir3");
    wr(`SHDM_OFS_TURNS, 32'h0, 1'b0, "turns0");
  endtask
  // Scale counting sense in both settings
  task automatic t_dir();
    sc.move(4);
    rd(`SHDM_OFS_SCALE, 32'hfffffffc, "lag");
    sc.move(-4);
    rd(`SHDM_OFS_SCALE, 32'h0, "lead");
    wr(`SHDM_OFS_CTRL, 32'h1, 1'b0, "inv");
    sc.move(4);
    rd(`SHDM_OFS_SCALE, 32'h4, "invlag");
    wr(`SHDM_OFS_CTRL, 32'h0, 1'b0, "noinv");
  endtask
  // Ratio arithmetic and the zero numerator
  task automatic t_ratio();
    wr(`SHDM_OFS_NUM, 32'h3, 1'b0, "num3");
    wr(`SHDM_OFS_DEN, 32'h2, 1'b0, "den2");
    wr(`SHDM_OFS_LIMIT, 32'h8000000, 1'b0, "limmax");
    pulse(2);
    en.move(-2);
    rd(`SHDM_OFS_DEV, 32'h6, "dev");
    sc.move(-3);
    rd(`SHDM_OFS_DEV, 32'h0, "dev");
    wr(`SHDM_OFS_NUM, 32'h0, 1'b0, "num0");
    pulse(2);
    en.move(-1);
    rd(`SHDM_OFS_DEV, 32'd16, "dev");
  endtask
  // Excess at the limit boundary, latch and alarm clear
  task automatic t_excess();
    wr(`SHDM_OFS_NUM, 32'h1, 1'b0, "num1");
    wr(`SHDM_OFS_DEN, 32'h1, 1'b0, "den1");
    // Zero the deviation left over before the limit drops to one
    pulse(2);
    wr(`SHDM_OFS_LIMIT, 32'h1, 1'b0, "lim1");
    wr(`SHDM_OFS_MASK, 32'h1, 1'b0, "mask");
    rd(`SHDM_OFS_INT, 32'h4, "int");
    en.move(-1);
    chk("err", 32'h0, {31'h0, herr});
    en.move(-1);
    chk("err", 32'h1, {31'h0, herr});
    rd(`SHDM_OFS_STATUS, 32'h1, "status");
    chk("irq", 32'h1, {31'h0, irq});
    pulse(2);
    chk("err", 32'h1, {31'h0, herr});
    wr(`SHDM_OFS_CTRL, 32'h10, 1'b0, "aclr");
    // Error drops at the answer edge, so look one cycle later
    @(posedge clk);
    chk("err", 32'h0, {31'h0, herr});
    rd(`SHDM_OFS_INT, 32'h5, "int");
    rd(`SHDM_OFS_INT, 32'h0, "int");
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  // Every initialisation event clears the deviation
  task automatic t_events();
    int i;
    wr(`SHDM_OFS_LIMIT, 32'h8000000, 1'b0, "limmax");
    wr(`SHDM_OFS_MASK, 32'h4, 1'b0, "mask");
    for (i = 0; i < 5; i++)
    begin
      en.move(-1);
      rd(`SHDM_OFS_DEV, 32'h1, "dev");
      pulse(i);
      rd(`SHDM_OFS_DEV, 32'h0, "evclr");
      chk("irq", 32'h1, {31'h0, irq});
      rd(`SHDM_OFS_INT, 32'h4, "int");
    end
  endtask
  // Periodic clear by encoder turns only
  task automatic t_turns();
    wr(`SHDM_OFS_MASK, 32'h0, 1'b0, "mask");
    pulse(2);
    en.move(-16);
    rd(`SHDM_OFS_DEV, 32'd16, "noclr");
    wr(`SHDM_OFS_TURNS, 32'h1, 1'b0, "turns1");
    pulse(2);
    rd(`SHDM_OFS_INT, 32'h4, "int");
    sc.move(-8);
    rd(`SHDM_OFS_DEV, 32'hfffffff8, "dev");
    en.move(-16);
    rd(`SHDM_OFS_DEV, 32'h0, "turnclr");
    rd(`SHDM_OFS_INT, 32'h2, "int");
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_refuse();
    t_dir();
    t_ratio();
    t_excess();
    t_events();
    t_turns();
    tally_and_finish();
  end
endmodule
